// ### hw/uart_lsr_pkg.sv
// Purpose: Constants and types for the line status and modem control block.
// Assumes: 8 data bits and one stop bit per character.
// Notes:   Register addresses use the three-bit decode of the host bus.
package uart_status_pkg;
	localparam int CLK_HZ     = 40_000_000;
	localparam int BAUD_RATE  = 115_200;
	localparam int OVERSAMPLE = 16;
	localparam int TICK_DIV   = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
	localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);
	localparam logic [3:0] HALF_BIT  = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hF;
	localparam logic [2:0] LAST_DATA = 3'h7;
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_IRQ_EN = 3'h1;
	localparam logic [2:0] A_IRQ_ID = 3'h2;
	localparam logic [2:0] A_LINE_CTRL = 3'h3;
	localparam logic [2:0] A_MODEM_CTRL = 3'h4;
	localparam logic [2:0] A_LINE_STATUS = 3'h5;
	localparam logic [2:0] A_MODEM_STATUS = 3'h6;
	localparam int MC_TERM_READY = 0;
	localparam int MC_SEND_REQ   = 1;
	localparam int MC_USER_A     = 2;
	localparam int MC_USER_B     = 3;
	localparam int MC_LOOP       = 4;
	localparam logic [7:0] MC_WRITABLE = 8'h1F;
	localparam int LC_PAR_EN = 3;
	localparam int LC_EVEN   = 4;
	localparam int LC_STICK  = 5;
	localparam int LC_BREAK  = 6;
	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_LINE = 2;
	localparam int IE_MODEM = 3;
	localparam logic [7:0] ID_NONE  = 8'h01;
	localparam logic [7:0] ID_LINE  = 8'h06;
	localparam logic [7:0] ID_RX    = 8'h04;
	localparam logic [7:0] ID_TX    = 8'h02;
	localparam logic [7:0] ID_MODEM = 8'h00;
	localparam int RX_FIFO_DEPTH = 8;
	localparam int RX_WORD_W     = 11;
	localparam logic [3:0] FRAME_PAR  = 4'hB;
	localparam logic [3:0] FRAME_BARE = 4'hA;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} rx_state_t;
endpackage : uart_status_pkg

// ### hw/uart_line_status_modem_ctrl.sv
// Purpose: Line status, modem control and loopback of a serial transceiver.
// Assumes: Host strobes are synchronous to clk; rd is a level, wr is taken at its leading edge.
// Notes:   Read side effects take place at the trailing edge of rd.

// ****************************************
// Receive buffer FIFO
// ****************************************
module rx_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	logic          push, pop;
	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_q + AW'(push);
			rp_q  <= rp_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : rx_fifo

// ****************************************
// Line status and modem control
// ****************************************
module uart_line_status_modem_ctrl import uart_status_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Host bus
	input  wire logic       cs,
	input  wire logic [2:0] addr,
	input  wire logic       rd,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	// Serial lines
	input  wire logic       serial_rx_pin,
	output logic            serial_tx_pin,
	// Modem inputs
	input  wire logic       clear_to_send_in_n,
	input  wire logic       set_ready_in_n,
	input  wire logic       bell_indicator_in_n,
	input  wire logic       carrier_detect_in_n,
	// Modem outputs
	output logic            term_ready_n,
	output logic            send_request_n,
	output logic            user_output_a_n,
	output logic            user_output_b_n,
	// Interrupt
	output logic            irq_line
);
	function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
		par_of = lc[LC_STICK] ? ~lc[LC_EVEN] : (^d ^ ~lc[LC_EVEN]);
	endfunction : par_of

	logic [7:0] mc_q, lc_q, rx_buffer, tx_holding, rdata_q;
	logic [3:0] ie_q, err_q, pend_q, ev, mstat_q, delta_q, min;
	logic [4:0] div_q;
	logic       tick, loop, rd_now, rd_act_q, wr_q, wr_take, rd_end, lstat_rd;
	logic [2:0] rd_addr_q;
	logic       data_ready, tx_hold_empty, tx_all_empty, hold_irq_q, irq_q;
	assign loop     = mc_q[MC_LOOP];
	assign rd_now   = cs & rd;
	assign rd_end   = rd_act_q & ~rd_now;
	assign wr_take  = cs & wr & ~wr_q;
	assign lstat_rd = rd_now & (addr == A_LINE_STATUS);

	// ****************************************
	// Bus strobes and registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_act_q  <= 1'b0;
			wr_q      <= 1'b0;
			rd_addr_q <= A_DATA;
			div_q     <= '0;
			tick      <= 1'b0;
		end else begin
			rd_act_q  <= rd_now;
			wr_q      <= cs & wr;
			rd_addr_q <= rd_now ? addr : rd_addr_q;
			div_q     <= (div_q == TICK_LAST) ? '0 : div_q + 5'h01;
			tick      <= div_q == TICK_LAST;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			mc_q <= 8'h00;
			lc_q <= 8'h00;
			ie_q <= 4'h0;
		end else if (wr_take) begin
			if (addr == A_MODEM_CTRL) mc_q <= wdata & MC_WRITABLE;
			if (addr == A_LINE_CTRL) lc_q <= wdata;
			if (addr == A_IRQ_EN) ie_q <= wdata[3:0];
		end
	end
	logic [7:0] irq_ident_reg;
	always_comb begin
		if (|err_q & ie_q[IE_LINE]) irq_ident_reg = ID_LINE;
		else if (data_ready & ie_q[IE_RX]) irq_ident_reg = ID_RX;
		else if (hold_irq_q & ie_q[IE_TX]) irq_ident_reg = ID_TX;
		else if (|delta_q & ie_q[IE_MODEM]) irq_ident_reg = ID_MODEM;
		else irq_ident_reg = ID_NONE;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (rd_now) begin
			case (addr)
				A_DATA:         rdata_q <= rx_buffer;
				A_IRQ_EN:       rdata_q <= {4'h0, ie_q};
				A_IRQ_ID:       rdata_q <= irq_ident_reg;
				A_LINE_CTRL:    rdata_q <= lc_q;
				A_MODEM_CTRL:   rdata_q <= mc_q & MC_WRITABLE;
				A_LINE_STATUS:  rdata_q <= {1'b0, tx_all_empty, tx_hold_empty, err_q, data_ready};
				A_MODEM_STATUS: rdata_q <= {mstat_q, delta_q};
				default:        rdata_q <= 8'h00;
			endcase
		end
	end
	assign rdata = rdata_q;

	// ****************************************
	// Receiver
	// ****************************************
	rx_state_t  rx_st;
	logic [3:0] rx_cnt;
	logic [2:0] rx_bit;
	logic [7:0] rx_sh;
	logic       rx_par, rx_in, dep, f_in_ready, f_out_valid, pop;
	logic [RX_WORD_W-1:0] dep_word, f_out;
	logic [10:0]          frame_q;
	// transmitter looped into receiver
	// The pin is parked at mark in loopback, so the receiver taps the shifter itself.
	assign rx_in = loop ? frame_q[0] : serial_rx_pin;
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_st  <= RX_IDLE;
			rx_cnt <= '0;
			rx_bit <= '0;
			rx_sh  <= '0;
			rx_par <= 1'b0;
			dep    <= 1'b0;
			dep_word <= '0;
		end else begin
			dep <= 1'b0;
			if (tick) begin
				rx_cnt <= rx_cnt + 4'h1;
				case (rx_st)
					RX_IDLE: begin
						rx_cnt <= '0;
						if (!rx_in) rx_st <= RX_START;
					end
					RX_START: if (rx_cnt == HALF_BIT) begin
						rx_cnt <= '0;
						rx_bit <= '0;
						rx_st  <= rx_in ? RX_IDLE : RX_DATA;
					end
					RX_DATA: if (rx_cnt == LAST_TICK) begin
						rx_sh  <= {rx_in, rx_sh[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == LAST_DATA) rx_st <= lc_q[LC_PAR_EN] ? RX_PAR : RX_STOP;
					end
					RX_PAR: if (rx_cnt == LAST_TICK) begin
						rx_par <= rx_in;
						rx_st  <= RX_STOP;
					end
					RX_STOP: if (rx_cnt == LAST_TICK) begin
						dep <= 1'b1;
						dep_word[10] <= ~rx_in & (rx_sh == 8'h00) & ~(lc_q[LC_PAR_EN] & rx_par);
						dep_word[9] <= ~rx_in & ~((rx_sh == 8'h00) & ~(lc_q[LC_PAR_EN] & rx_par));
						dep_word[8] <= lc_q[LC_PAR_EN] & (rx_par != par_of(rx_sh, lc_q));
						dep_word[7:0] <= rx_sh;
						rx_st <= rx_in ? RX_IDLE : RX_HOLD;
					end
					RX_HOLD: if (rx_in) rx_st <= RX_IDLE;
					default: rx_st <= RX_IDLE;
				endcase
			end
		end
	end
	// buffer load waits out a status read
	assign pop = f_out_valid & ~data_ready & ~lstat_rd;
	rx_fifo #(.W(RX_WORD_W), .DEPTH(RX_FIFO_DEPTH)) u_fifo (
		.clk(clk), .rst(rst),
		.in_valid(dep), .in_ready(f_in_ready), .in_data(dep_word),
		.out_valid(f_out_valid), .out_ready(pop), .out_data(f_out)
	);
	assign ev = dep ? {dep_word[10:8], ~f_in_ready} : 4'h0;
	always_ff @(posedge clk) begin
		if (rst) begin
			data_ready <= 1'b0;
			rx_buffer  <= 8'h00;
		end else if (pop) begin
			data_ready <= 1'b1;
			rx_buffer  <= f_out[7:0];
		end else if (rd_end && rd_addr_q == A_DATA) begin
			data_ready <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			err_q  <= 4'h0;
			pend_q <= 4'h0;
		end else if (lstat_rd) begin
			pend_q <= pend_q | ev;
		end else if (rd_end && rd_addr_q == A_LINE_STATUS) begin
			err_q  <= pend_q | ev;
			pend_q <= 4'h0;
		end else begin
			err_q <= err_q | ev;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	logic [3:0]  tx_cnt, tx_left;
	logic        tx_busy, load;
	// shifter load waits out a status read
	assign load = ~tx_hold_empty & ~tx_busy & ~lstat_rd;
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_hold_empty <= 1'b1;
			tx_holding    <= 8'h00;
		end else begin
			// set on transfer, clear on write
			if (load) tx_hold_empty <= 1'b1;
			if (wr_take && addr == A_DATA) begin
				tx_holding    <= wdata;
				tx_hold_empty <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_busy      <= 1'b0;
			tx_all_empty <= 1'b1;
			frame_q      <= '1;
			tx_cnt       <= '0;
			tx_left      <= '0;
		end else begin
			if (load) begin
				tx_busy <= 1'b1;
				tx_cnt  <= '0;
				frame_q <= lc_q[LC_PAR_EN] ? {1'b1, par_of(tx_holding, lc_q), tx_holding, 1'b0}
				                           : {2'b11, tx_holding, 1'b0};
				tx_left <= lc_q[LC_PAR_EN] ? FRAME_PAR : FRAME_BARE;
			end else if (tick && tx_busy) begin
				tx_cnt <= tx_cnt + 4'h1;
				if (tx_cnt == LAST_TICK) begin
					frame_q <= {1'b1, frame_q[10:1]};
					tx_left <= tx_left - 4'h1;
					if (tx_left == 4'h1) tx_busy <= 1'b0;
				end
			end
			// empty only with holding and shifter empty
			if (wr_take && addr == A_DATA) tx_all_empty <= 1'b0;
			else if (!tx_busy && tx_hold_empty && !lstat_rd) tx_all_empty <= 1'b1;
		end
	end

	// ****************************************
	// Modem lines and interrupt
	// ****************************************
	// inputs replaced by control bits in loopback
	assign min = loop ? {mc_q[MC_USER_B], mc_q[MC_USER_A], mc_q[MC_TERM_READY], mc_q[MC_SEND_REQ]}
	                  : ~{carrier_detect_in_n, bell_indicator_in_n, set_ready_in_n,
	                      clear_to_send_in_n};
	always_ff @(posedge clk) begin
		if (rst) begin
			mstat_q <= 4'h0;
			delta_q <= 4'h0;
		end else begin
			mstat_q <= min;
			if (rd_end && rd_addr_q == A_MODEM_STATUS)
				delta_q <= {min[3] ^ mstat_q[3], mstat_q[2] & ~min[2], min[1:0] ^ mstat_q[1:0]};
			else
				delta_q <= delta_q | {min[3] ^ mstat_q[3], mstat_q[2] & ~min[2],
				                      min[1:0] ^ mstat_q[1:0]};
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_irq_q <= 1'b0;
		end else if (load || (wr_take && addr == A_IRQ_EN && wdata[IE_TX] && tx_hold_empty)) begin
			hold_irq_q <= 1'b1;
		end else if ((wr_take && addr == A_DATA) ||
		             (rd_end && rd_addr_q == A_IRQ_ID && rdata_q == ID_TX)) begin
			hold_irq_q <= 1'b0;
		end
	end
	assign irq_q = (irq_ident_reg != ID_NONE);
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_line        <= 1'b0;
			serial_tx_pin   <= 1'b1;
			term_ready_n    <= 1'b1;
			send_request_n  <= 1'b1;
			user_output_a_n <= 1'b1;
			user_output_b_n <= 1'b1;
		end else begin
			irq_line        <= irq_q;
			serial_tx_pin   <= loop | (frame_q[0] & ~lc_q[LC_BREAK]);
			term_ready_n    <= loop | ~mc_q[MC_TERM_READY];
			send_request_n  <= loop | ~mc_q[MC_SEND_REQ];
			user_output_a_n <= loop | ~mc_q[MC_USER_A];
			user_output_b_n <= loop | ~mc_q[MC_USER_B];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_status_top_zero: assert property ($past(lstat_rd) |-> !rdata[7])
		else $error("line status top bit not zero");
	a_ctrl_high_zero: assert property ($past(rd_now && addr == A_MODEM_CTRL) |-> rdata[7:5] == 3'h0)
		else $error("modem control upper bits not zero");
	a_ready_clear: assert property (rd_end && rd_addr_q == A_DATA |=> !data_ready)
		else $error("data ready not cleared by buffer read");
	a_err_clear: assert property (rd_end && rd_addr_q == A_LINE_STATUS && pend_q == 4'h0 && ev == 4'h0
		|=> err_q == 4'h0)
		else $error("error flags not cleared by status read");
	a_err_holdoff: assert property (lstat_rd |=> err_q == $past(err_q))
		else $error("error flag changed during status read");
	a_hold_write: assert property (wr_take && addr == A_DATA |=> !tx_hold_empty && !tx_all_empty)
		else $error("holding write did not clear empty flags");
	a_empty_order: assert property (tx_all_empty |-> tx_hold_empty && !tx_busy)
		else $error("transmitter empty while data pending");
	a_loop_pins: assert property (loop |=> term_ready_n && send_request_n && user_output_a_n
		&& user_output_b_n && serial_tx_pin)
		else $error("pins active in loopback");
	a_ready_pin: assert property (!loop |=> term_ready_n == !$past(mc_q[MC_TERM_READY]))
		else $error("terminal ready pin wrong");
	a_line_irq: assert property (|err_q && ie_q[IE_LINE] |=> irq_line)
		else $error("line interrupt missing");
	a_loop_status: assert property (loop |=> mstat_q[0] == $past(mc_q[MC_SEND_REQ]))
		else $error("loopback status not following control");
	c_overrun: cover property (dep && !f_in_ready);
	c_break: cover property (dep && dep_word[10]);
	c_loop_char: cover property (loop && pop);
endmodule : uart_line_status_modem_ctrl

// ### bench/serial_modem_model.sv
// Purpose: Far-end serial line and modem model for the line status bench.
// Assumes: One frame at a time; timing from the package bit rate.
// Notes:   The line idles at mark between frames, as a real sender would.
module serial_modem_model import uart_status_pkg::*; (
	// Clock
	input  wire logic clk,
	// Serial line towards the receiver
	output logic      serial_rx_pin,
	// Modem inputs, active low
	output logic      clear_to_send_in_n,
	output logic      set_ready_in_n,
	output logic      bell_indicator_in_n,
	output logic      carrier_detect_in_n
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int BIT_CLKS = TICK_DIV * OVERSAMPLE;

	initial begin
		serial_rx_pin = 1'b1;
		{carrier_detect_in_n, bell_indicator_in_n, set_ready_in_n, clear_to_send_in_n} = 4'hF;
	end

	task automatic set_line(input logic v);
		@(posedge clk);
		serial_rx_pin <= v;
	endtask : set_line

	task automatic hold_bit(input logic v);
		set_line(v);
		repeat (BIT_CLKS - 1) @(posedge clk);
	endtask : hold_bit

	task automatic set_modem(input logic [3:0] n);
		@(posedge clk);
		{carrier_detect_in_n, bell_indicator_in_n, set_ready_in_n, clear_to_send_in_n} <= n;
	endtask : set_modem

	// A low stop bit here lets the bench provoke framing and break cases.
	task automatic send_frame(input logic [7:0] d, input logic par_on, input logic par_bit,
			input logic stop_bit);
		int i;
		hold_bit(1'b0);
		for (i = 0; i < 8; i++) begin
			hold_bit(d[i]);
		end
		if (par_on) begin
			hold_bit(par_bit);
		end
		hold_bit(stop_bit);
		hold_bit(1'b1);
	endtask : send_frame
endmodule : serial_modem_model

// ### bench/uart_line_status_modem_ctrl_tb.sv
// Purpose: Self-checking bench for line status and modem control.
// Assumes: Eight data bits, one stop bit, fixed bit rate.
// Notes:   Error cases wait on the interrupt, since status polling clears flags.
module uart_line_status_modem_ctrl_tb import uart_status_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [7:0] wv;
		logic [3:0] pins;
		logic [7:0] rb;
		logic [3:0] outs;
		logic [3:0] modem_status_reg;
	} row_t;

	logic       clk, rst, cs, rd, wr, loop_on, tx_low;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v;
	logic       serial_rx_pin, serial_tx_pin, irq_line;
	logic       cts_n, dsr_n, bell_n, carrier_n, dtr_n, rts_n, ua_n, ub_n;
	int         bad_count, samples_checked;
	row_t       rows [11] = '{
		'{8'h00, 4'hF, 8'h00, 4'hF, 4'h0}, '{8'h01, 4'hF, 8'h01, 4'hE, 4'h0},
		'{8'h02, 4'hE, 8'h02, 4'hD, 4'h1}, '{8'h04, 4'h5, 8'h04, 4'hB, 4'hA},
		'{8'h08, 4'hF, 8'h08, 4'h7, 4'h0}, '{8'hEF, 4'hF, 8'h0F, 4'h0, 4'h0},
		'{8'hFF, 4'h0, 8'h1F, 4'hF, 4'hF}, '{8'h12, 4'h0, 8'h12, 4'hF, 4'h1},
		'{8'h11, 4'h0, 8'h11, 4'hF, 4'h2}, '{8'h14, 4'h0, 8'h14, 4'hF, 4'h4},
		'{8'h18, 4'h0, 8'h18, 4'hF, 4'h8}};

	uart_line_status_modem_ctrl i_dut (.clk(clk), .rst(rst), .cs(cs), .addr(addr), .rd(rd),
		.wr(wr), .wdata(wdata), .rdata(rdata), .serial_rx_pin(serial_rx_pin),
		.serial_tx_pin(serial_tx_pin), .clear_to_send_in_n(cts_n), .set_ready_in_n(dsr_n),
		.bell_indicator_in_n(bell_n), .carrier_detect_in_n(carrier_n), .term_ready_n(dtr_n),
		.send_request_n(rts_n), .user_output_a_n(ua_n), .user_output_b_n(ub_n),
		.irq_line(irq_line));

	serial_modem_model i_partner (.clk(clk), .serial_rx_pin(serial_rx_pin),
		.clear_to_send_in_n(cts_n), .set_ready_in_n(dsr_n), .bell_indicator_in_n(bell_n),
		.carrier_detect_in_n(carrier_n));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (rst) begin
			tx_low <= 1'b0;
		end else if (loop_on && serial_tx_pin !== 1'b1) begin
			tx_low <= 1'b1;
		end
	end

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic print_verdict();
		$display("Mismatches %0d, comparisons %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		cs <= 1'b1;
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		cs <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : reg_wr

	// The extra edges let the trailing-edge side effects and the irq register land.
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		cs <= 1'b1;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		cs <= 1'b0;
		rd <= 1'b0;
		#1;
		d = rdata;
		repeat (3) @(posedge clk);
		#1;
	endtask : reg_rd

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_rd(a, d);
		chk(d, exp);
	endtask : rd_chk

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_line !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			bad_count++;
			print_verdict();
		end
		repeat (4) @(posedge clk);
	endtask : wait_irq

	task automatic poll_status(input int b, input int lim);
		int n;
		n = 0;
		v = 8'h00;
		while (v[b] !== 1'b1 && n < lim) begin
			reg_rd(A_LINE_STATUS, v);
			n++;
		end
		if (v[b] !== 1'b1) begin
			bad_count++;
			print_verdict();
		end
	endtask : poll_status

	task automatic pulse_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
	endtask : pulse_reset

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, cs, rd, wr, loop_on} = 5'b10000;
		addr = 3'h0;
		wdata = 8'h00;
		bad_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_chk(A_LINE_STATUS, 8'h60);
		rd_chk(A_MODEM_CTRL, 8'h00);
		rd_chk(3'h7, 8'h00);
		reg_wr(A_LINE_STATUS, 8'hFF);
		rd_chk(A_LINE_STATUS, 8'h60);
		foreach (rows[i]) begin
			i_partner.set_modem(rows[i].pins);
			reg_wr(A_MODEM_CTRL, rows[i].wv);
			rd_chk(A_MODEM_CTRL, rows[i].rb);
			chk({4'h0, ub_n, ua_n, rts_n, dtr_n}, {4'h0, rows[i].outs});
			reg_rd(A_MODEM_STATUS, v);
			chk({4'h0, v[7:4]}, {4'h0, rows[i].modem_status_reg});
		end
		reg_wr(A_MODEM_CTRL, 8'h00);
		i_partner.set_modem(4'hF);
		i_partner.send_frame(8'hA5, 1'b0, 1'b0, 1'b1);
		poll_status(0, 50);
		rd_chk(A_DATA, 8'hA5);
		rd_chk(A_LINE_STATUS, 8'h60);
		// Even parity with a wrong parity bit.
		reg_wr(A_IRQ_EN, 8'h04);
		reg_wr(A_LINE_CTRL, 8'h18);
		i_partner.send_frame(8'hA5, 1'b1, 1'b1, 1'b1);
		wait_irq();
		rd_chk(A_IRQ_ID, ID_LINE);
		rd_chk(A_LINE_STATUS, 8'h65);
		chk({7'h0, irq_line}, 8'h00);
		rd_chk(A_LINE_STATUS, 8'h61);
		rd_chk(A_DATA, 8'hA5);
		reg_wr(A_LINE_CTRL, 8'h00);
		// Low stop bit; reset afterwards to drop the unread character from the buffer.
		i_partner.send_frame(8'h5A, 1'b0, 1'b0, 1'b0);
		wait_irq();
		rd_chk(A_LINE_STATUS, 8'h69);
		pulse_reset();
		rd_chk(A_LINE_STATUS, 8'h60);
		reg_wr(A_IRQ_EN, 8'h04);
		i_partner.send_frame(8'h00, 1'b0, 1'b0, 1'b0);
		wait_irq();
		rd_chk(A_LINE_STATUS, 8'h71);
		rd_chk(A_DATA, 8'h00);
		// Buffer plus eight queued words, so the tenth character is lost.
		repeat (10) i_partner.send_frame(8'h33, 1'b0, 1'b0, 1'b1);
		wait_irq();
		rd_chk(A_LINE_STATUS, 8'h63);
		rd_chk(A_LINE_STATUS, 8'h61);
		pulse_reset();
		// Loopback transmit with the external line held at space.
		i_partner.set_line(1'b0);
		reg_wr(A_MODEM_CTRL, 8'h10);
		loop_on = 1'b1;
		reg_wr(A_IRQ_EN, 8'h02);
		repeat (2) @(posedge clk);
		#1;
		chk({7'h0, irq_line}, 8'h01);
		rd_chk(A_IRQ_ID, ID_TX);
		chk({7'h0, irq_line}, 8'h00);
		reg_wr(A_DATA, 8'h55);
		reg_rd(A_LINE_STATUS, v);
		chk(v & 8'h40, 8'h00);
		poll_status(5, 20);
		reg_rd(A_LINE_STATUS, v);
		chk(v & 8'h60, 8'h20);
		poll_status(6, 2000);
		poll_status(0, 50);
		rd_chk(A_DATA, 8'h55);
		// Loopback modem interrupt raised from a control bit.
		reg_rd(A_MODEM_STATUS, v);
		reg_wr(A_IRQ_EN, 8'h08);
		reg_wr(A_MODEM_CTRL, 8'h11);
		rd_chk(A_IRQ_ID, ID_MODEM);
		rd_chk(A_MODEM_STATUS, 8'h22);
		chk({7'h0, tx_low}, 8'h00);
		loop_on = 1'b0;
		i_partner.set_line(1'b1);
		reg_wr(A_MODEM_CTRL, 8'h00);
		rd_chk(A_LINE_STATUS, 8'h60);
		print_verdict();
	end
endmodule : uart_line_status_modem_ctrl_tb
